// [verilog/mpi_pkg.sv]
package mpi_pkg;
    // object dictionary indices of the phasing parameters
    localparam logic [15:0] MPI_IDX_METHOD = 16'h21c0;
    localparam logic [15:0] MPI_IDX_CUR_LIMIT = 16'h21c2;
    localparam logic [15:0] MPI_IDX_DURATION = 16'h21c3;
    localparam logic [15:0] MPI_IDX_OPTIONS = 16'h21c4;

    // phasing selection codes
    localparam logic [15:0] MPI_SEL_HALL_ENC = 16'h0000;
    localparam logic [15:0] MPI_SEL_TRAP = 16'h0001;
    localparam logic [15:0] MPI_SEL_HALL_INIT = 16'h0002;
    localparam logic [15:0] MPI_SEL_ANALOG = 16'h0003;
    localparam logic [15:0] MPI_SEL_BRUSH = 16'h0004;
    localparam logic [15:0] MPI_SEL_ALGO = 16'h0005;
    localparam logic [15:0] MPI_SEL_ENC = 16'h0006;
    localparam logic [15:0] MPI_SEL_TRAP_INTERP = 16'h0007;

    // reset values
    localparam logic [15:0] MPI_RST_METHOD = 16'h0000;
    localparam logic [15:0] MPI_RST_CUR_LIMIT = 16'h0000;
    localparam logic [15:0] MPI_RST_DURATION = 16'h0000;
    localparam logic [15:0] MPI_RST_OPTIONS = 16'h0000;

    // option bits
    localparam int MPI_OPT_FORCE_ZERO = 0;
    localparam int MPI_OPT_STEP90 = 1;
    localparam int MPI_OPT_HALL_OFS = 2;

    // status bit positions
    localparam int MPI_MSTAT_INIT_BIT = 29;
    localparam int MPI_SW_PHASE_ERR_BIT = 6;

    // angle: 16 bits per electrical turn, so 90 degrees is a quarter
    localparam logic [15:0] MPI_ANGLE_90 = 16'h4000;
    localparam logic [15:0] MPI_ANGLE_ZERO = 16'h0000;

    // timing: 1 ms pacing tick from the 20 MHz clock
    localparam int MPI_CLK_HZ = 20000000;
    localparam int MPI_TICK_US = 1000;
    localparam int MPI_TICK_CYC = MPI_CLK_HZ / 1000000 * MPI_TICK_US;
    localparam logic [15:0] MPI_TICK_LAST = 16'(MPI_TICK_CYC - 1);

    // sources of the commutation angle
    typedef enum logic [5:0] {
        MPI_SRC_HALL = 6'h01,
        MPI_SRC_ENC = 6'h02,
        MPI_SRC_ENC_HALLFIX = 6'h04,
        MPI_SRC_ANALOG = 6'h08,
        MPI_SRC_INTERP = 6'h10,
        MPI_SRC_NONE = 6'h20
    } mpi_src_t;

    typedef enum logic [4:0] {
        MPI_ST_IDLE = 5'h01,
        MPI_ST_WAIT_EN = 5'h02,
        MPI_ST_SEARCH = 5'h04,
        MPI_ST_DONE = 5'h08,
        MPI_ST_FAIL = 5'h10
    } mpi_state_t;
endpackage

// [verilog/mpi_phasing.sv]
`timescale 1ns/1ns
module mpi_phasing (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] index_i,
    input wire logic [15:0] wdata_i,
    input wire logic drive_enable_i,
    input wire logic analog_hall_present_i,
    input wire logic [15:0] hall_offset_i,
    input wire logic attempt_ok_i,
    input wire logic attempt_fail_i,
    input wire logic profile_req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic mfg_init_busy_o,
    output logic sw_phase_err_o,
    output logic drive_disable_o,
    output logic profile_start_o,
    output logic init_active_o,
    output logic [15:0] init_angle_o,
    output logic [15:0] init_current_o,
    output logic attempt_timeout_o,
    output logic [5:0] angle_src_o
);
    import mpi_pkg::*;

    logic [15:0] method_r, method_nxt;
    logic [15:0] cur_r, cur_nxt;
    logic [15:0] dur_r, dur_nxt;
    logic [15:0] opt_r, opt_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic en_s1_r, en_s2_r;
    mpi_state_t st_r, st_nxt;
    logic busy_r, busy_nxt;
    logic err_r, err_nxt;
    logic dis_r, dis_nxt;
    logic first_r, first_nxt;
    logic [15:0] angle_r, angle_nxt;
    logic [15:0] icur_r, icur_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic [15:0] ms_r, ms_nxt;
    logic tmo_r, tmo_nxt;
    logic prof_r, prof_nxt;
    mpi_src_t src_r, src_nxt;
    logic act_r, act_nxt;
    logic wr_method;
    logic algo_sel;

    function automatic logic [15:0] clamp_mag(input logic [15:0] lim);
        // negative limit taken as its magnitude; current is a magnitude here
        clamp_mag = lim[15] ? 16'(-lim) : lim;
    endfunction

    assign wr_method = wr_i && (index_i == MPI_IDX_METHOD);
    assign algo_sel = (method_r == MPI_SEL_ALGO);

    // register file
    // unmapped indices read zero and drop writes, so stray accesses stay harmless
    always_comb begin
        method_nxt = method_r;
        cur_nxt = cur_r;
        dur_nxt = dur_r;
        opt_nxt = opt_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (wr_i) begin
            unique case (index_i)
                MPI_IDX_METHOD: method_nxt = wdata_i;
                MPI_IDX_CUR_LIMIT: cur_nxt = wdata_i;
                MPI_IDX_DURATION: dur_nxt = wdata_i;
                MPI_IDX_OPTIONS: opt_nxt = wdata_i;
                default: ;
            endcase
        end
        if (rd_i) begin
            rvalid_nxt = 1'b1;
            unique case (index_i)
                MPI_IDX_METHOD: rdata_nxt = method_r;
                MPI_IDX_CUR_LIMIT: rdata_nxt = cur_r;
                MPI_IDX_DURATION: rdata_nxt = dur_r;
                MPI_IDX_OPTIONS: rdata_nxt = opt_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            method_r <= MPI_RST_METHOD;
            cur_r <= MPI_RST_CUR_LIMIT;
            dur_r <= MPI_RST_DURATION;
            opt_r <= MPI_RST_OPTIONS;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            method_r <= method_nxt;
            cur_r <= cur_nxt;
            dur_r <= dur_nxt;
            opt_r <= opt_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // enable comes from another part of the drive, treated as asynchronous
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else begin
            en_s1_r <= drive_enable_i;
            en_s2_r <= en_s1_r;
        end
    end

    // angle source follows the selection; encoder in mode 6 always, in modes 2 and 5 only once start-up is done
    always_comb begin
        src_nxt = src_r;
        unique case (method_r)
            MPI_SEL_HALL_ENC: src_nxt = MPI_SRC_ENC_HALLFIX;
            MPI_SEL_TRAP: src_nxt = MPI_SRC_HALL;
            MPI_SEL_HALL_INIT: src_nxt = (st_r == MPI_ST_DONE) ? MPI_SRC_ENC : MPI_SRC_HALL;
            MPI_SEL_ANALOG: src_nxt = analog_hall_present_i ? MPI_SRC_ANALOG : MPI_SRC_NONE;
            MPI_SEL_ENC: src_nxt = MPI_SRC_ENC;
            MPI_SEL_TRAP_INTERP: src_nxt = MPI_SRC_INTERP;
            MPI_SEL_ALGO: src_nxt = (st_r == MPI_ST_DONE) ? MPI_SRC_ENC : MPI_SRC_NONE;
            default: src_nxt = MPI_SRC_NONE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_r <= MPI_SRC_NONE;
        end else begin
            src_r <= src_nxt;
        end
    end

    // phase init machine
    always_comb begin
        st_nxt = st_r;
        busy_nxt = busy_r;
        err_nxt = err_r;
        dis_nxt = dis_r;
        first_nxt = first_r;
        angle_nxt = angle_r;
        icur_nxt = 16'h0000;
        tick_nxt = tick_r;
        ms_nxt = ms_r;
        tmo_nxt = 1'b0;
        // for modes 0 and 2, Hall start-up is what DONE means; it follows the first cycle in mode
        unique case (st_r)
            MPI_ST_IDLE: begin
                if (algo_sel) begin
                    st_nxt = MPI_ST_WAIT_EN;
                    busy_nxt = 1'b1;
                    first_nxt = 1'b1;
                end else if (method_r == MPI_SEL_HALL_INIT || method_r == MPI_SEL_HALL_ENC) begin
                    st_nxt = MPI_ST_DONE;
                end
            end
            MPI_ST_WAIT_EN: begin
                if (en_s2_r) begin
                    st_nxt = MPI_ST_SEARCH;
                    tick_nxt = 16'h0000;
                    ms_nxt = 16'h0000;
                    if (opt_r[MPI_OPT_FORCE_ZERO]) begin
                        angle_nxt = MPI_ANGLE_ZERO;
                    end else if (first_r && opt_r[MPI_OPT_HALL_OFS]) begin
                        angle_nxt = hall_offset_i;
                    end else if (first_r) begin
                        angle_nxt = MPI_ANGLE_ZERO;
                    end
                end
            end
            MPI_ST_SEARCH: begin
                icur_nxt = clamp_mag(cur_r);
                // ms count moves only at tick wrap, so the duration is met on a ms boundary
                if (tick_r == MPI_TICK_LAST) begin
                    tick_nxt = 16'h0000;
                    ms_nxt = 16'(ms_r + 16'h0001);
                end else begin
                    tick_nxt = 16'(tick_r + 16'h0001);
                end
                if (!en_s2_r) begin
                    st_nxt = MPI_ST_WAIT_EN;
                    first_nxt = 1'b1;
                end else if (opt_r[MPI_OPT_FORCE_ZERO]) begin
                    st_nxt = MPI_ST_DONE;
                    busy_nxt = 1'b0;
                end else if (attempt_ok_i) begin
                    st_nxt = MPI_ST_DONE;
                    busy_nxt = 1'b0;
                end else if (attempt_fail_i || (ms_r >= dur_r && tick_r == MPI_TICK_LAST)) begin
                    tmo_nxt = !attempt_fail_i;
                    st_nxt = MPI_ST_FAIL;
                    err_nxt = 1'b1;
                    // disable request holds until software rewrites the selection
                    dis_nxt = 1'b1;
                    if (opt_r[MPI_OPT_STEP90]) begin
                        angle_nxt = 16'(angle_r + MPI_ANGLE_90);
                    end
                end
            end
            MPI_ST_DONE: ;
            MPI_ST_FAIL: ; // bit 29 stays set until a selection other than mode 5 is written
            default: st_nxt = MPI_ST_IDLE;
        endcase
        if (wr_method) begin
            if (wdata_i == MPI_SEL_ALGO) begin
                // later attempts keep the stepped angle, so a write sets first only from idle or done; an enable drop mid-search also sets it
                st_nxt = MPI_ST_WAIT_EN;
                busy_nxt = 1'b1;
                err_nxt = 1'b0;
                dis_nxt = 1'b0;
                first_nxt = (st_r == MPI_ST_IDLE) || (st_r == MPI_ST_DONE);
            end else begin
                st_nxt = MPI_ST_IDLE;
                busy_nxt = 1'b0;
                err_nxt = 1'b0;
                dis_nxt = 1'b0;
            end
        end
        // flop copy of the search flag; on disable it drops a cycle after the synced enable
        act_nxt = busy_nxt && !err_nxt && en_s2_r && (st_nxt == MPI_ST_SEARCH);
    end

    // profile gating
    // mode 5 before done blocks as well as busy, so a cleared busy alone cannot start a profile
    always_comb begin
        prof_nxt = profile_req_i && !(algo_sel && st_r != MPI_ST_DONE) && !busy_r;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prof_r <= 1'b0;
        end else begin
            prof_r <= prof_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= MPI_ST_IDLE;
            busy_r <= 1'b0;
            err_r <= 1'b0;
            dis_r <= 1'b0;
            first_r <= 1'b1;
            angle_r <= MPI_ANGLE_ZERO;
            icur_r <= 16'h0000;
            tick_r <= 16'h0000;
            ms_r <= 16'h0000;
            tmo_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            busy_r <= busy_nxt;
            err_r <= err_nxt;
            dis_r <= dis_nxt;
            first_r <= first_nxt;
            angle_r <= angle_nxt;
            icur_r <= icur_nxt;
            tick_r <= tick_nxt;
            ms_r <= ms_nxt;
            tmo_r <= tmo_nxt;
            act_r <= act_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign mfg_init_busy_o = busy_r;
    assign sw_phase_err_o = err_r;
    assign drive_disable_o = dis_r;
    assign profile_start_o = prof_r;
    assign init_active_o = act_r;
    assign init_angle_o = angle_r;
    assign init_current_o = icur_r;
    assign attempt_timeout_o = tmo_r;
    assign angle_src_o = src_r;
endmodule

// [sim/mpi_phasing_assertions.sv]
`timescale 1ns/1ns
module mpi_chk (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [15:0] index_i,
    input wire logic [15:0] wdata_i,
    input wire logic drive_enable_i,
    input wire logic attempt_ok_i,
    input wire logic attempt_fail_i,
    input wire logic profile_req_i,
    input wire logic mfg_init_busy_o,
    input wire logic sw_phase_err_o,
    input wire logic drive_disable_o,
    input wire logic profile_start_o,
    input wire logic init_active_o,
    input wire logic [15:0] init_current_o,
    input wire logic [5:0] angle_src_o
);
    import mpi_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic mwr;
    assign mwr = wr_i && index_i == MPI_IDX_METHOD;
    busy_set_a: assert property (mwr && wdata_i == MPI_SEL_ALGO |=> mfg_init_busy_o)
        else $error("busy not set");
    busy_clear_a: assert property (mwr && wdata_i != MPI_SEL_ALGO |=> !mfg_init_busy_o)
        else $error("busy kept");
    profile_gate_a: assert property (profile_start_o |-> $past(profile_req_i && !mfg_init_busy_o))
        else $error("profile while busy");
    err_hold_a: assert property (sw_phase_err_o |-> mfg_init_busy_o && drive_disable_o)
        else $error("error without busy");
    fail_err_a: assert property (init_active_o && $past(drive_enable_i, 2) && attempt_fail_i && !attempt_ok_i |=> sw_phase_err_o)
        else $error("fail not flagged");
    ok_done_a: assert property (init_active_o && $past(drive_enable_i, 2) && attempt_ok_i |=> !mfg_init_busy_o ##1 angle_src_o == MPI_SRC_ENC)
        else $error("done not encoder");
    stop_off_a: assert property (!drive_enable_i [*3] |=> !init_active_o)
        else $error("search while off");
    cur_zero_a: assert property (!mfg_init_busy_o && $past(!mfg_init_busy_o) |-> init_current_o == 16'h0000)
        else $error("current outside init");
    cover property (init_active_o && attempt_ok_i);
    cover property (sw_phase_err_o);
    cover property (profile_start_o);
endmodule

bind mpi_phasing mpi_chk u_chk (.*);

// [sim/mpi_sensor_model.sv]
`timescale 1ns/1ns
module mpi_sensor_model (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic init_active_i,
    input wire logic [1:0] ans_i,
    output logic attempt_ok_o,
    output logic attempt_fail_o
);
    logic [2:0] cnt;
    // answers only while a search runs, a few cycles in; ans 0 never answers
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 3'h0;
            attempt_ok_o <= 1'b0;
            attempt_fail_o <= 1'b0;
        end else begin
            attempt_ok_o <= 1'b0;
            attempt_fail_o <= 1'b0;
            if (!init_active_i || attempt_ok_o || attempt_fail_o) begin
                cnt <= 3'h0;
            end else if (cnt == 3'h5) begin
                attempt_ok_o <= ans_i == 2'h1;
                attempt_fail_o <= ans_i == 2'h2;
                cnt <= 3'h0;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule

// [sim/mpi_phasing_bench.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
`define WAITF(c) begin for (i = 0; !(c) && i < 30000; i++) tick(1); if (!(c)) begin err_count++; conclude(); end end
module mpi_phasing_bench;
    import mpi_pkg::*;
    logic sys_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, en = 0, ana = 0, req = 0;
    logic [15:0] idx = 0, wd = 0, hofs = 16'h1234;
    logic [1:0] ans = 0;
    logic ok, fail, rvalid, busy, err, dis, pst, act, tmo;
    logic [15:0] rdata, ang, cur;
    logic [5:0] src;
    int err_count = 0, tests_run = 0, i;
    logic [15:0] ri [4] = '{MPI_IDX_METHOD, MPI_IDX_CUR_LIMIT, MPI_IDX_DURATION, MPI_IDX_OPTIONS};
    logic [15:0] rv [4] = '{MPI_RST_METHOD, MPI_RST_CUR_LIMIT, MPI_RST_DURATION, MPI_RST_OPTIONS};
    logic [5:0] xs [8] = '{MPI_SRC_ENC_HALLFIX, MPI_SRC_HALL, MPI_SRC_ENC, MPI_SRC_ANALOG, MPI_SRC_NONE,
        MPI_SRC_NONE, MPI_SRC_ENC, MPI_SRC_INTERP};
    always #25 sys_clk_i = ~sys_clk_i;
    mpi_phasing dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wr_i(wr_i), .rd_i(rd_i), .index_i(idx),
        .wdata_i(wd), .drive_enable_i(en), .analog_hall_present_i(ana), .hall_offset_i(hofs),
        .attempt_ok_i(ok), .attempt_fail_i(fail), .profile_req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .mfg_init_busy_o(busy), .sw_phase_err_o(err), .drive_disable_o(dis), .profile_start_o(pst),
        .init_active_o(act), .init_angle_o(ang), .init_current_o(cur), .attempt_timeout_o(tmo),
        .angle_src_o(src));
    mpi_sensor_model hall (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .init_active_i(act), .ans_i(ans),
        .attempt_ok_o(ok), .attempt_fail_o(fail));
    task conclude;
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // strobe drops for a cycle so back-to-back calls never retouch it in one step
    task wr(input logic [15:0] a, input logic [15:0] d);
        idx = a;
        wd = d;
        wr_i = 1;
        tick(1);
        wr_i = 0;
        tick(1);
    endtask
    task rd(input logic [15:0] a, input logic [15:0] e);
        idx = a;
        rd_i = 1;
        tick(1);
        rd_i = 0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
        tick(1);
    endtask
    initial begin
        tick(8);
        rstn_i = 1;
        tick(1);
        req = 1;
        for (int k = 0; k < 4; k++) rd(ri[k], rv[k]);
        wr(16'h21c1, 16'hffff);
        rd(16'h21c1, 16'h0000);
        for (int k = 0; k < 4; k++) wr(ri[k], 16'(16 * k + 1));
        for (int k = 0; k < 4; k++) rd(ri[k], 16'(16 * k + 1));
        en = 1;
        ana = 1;
        for (int m = 0; m < 8; m++) begin
            if (m != 5) begin
                wr(MPI_IDX_METHOD, 16'(m));
                tick(4);
                `CHK("source", xs[m], src)
            end
        end
        ana = 0;
        wr(MPI_IDX_METHOD, MPI_SEL_ANALOG);
        tick(2);
        `CHK("no analog", 6'(MPI_SRC_NONE), src)
        en = 0;
        wr(MPI_IDX_CUR_LIMIT, 16'h0123);
        wr(MPI_IDX_DURATION, 16'h0064);
        wr(MPI_IDX_OPTIONS, 16'h0000);
        wr(MPI_IDX_METHOD, MPI_SEL_ALGO);
        `CHK("busy", 1'b1, busy)
        tick(6);
        `CHK("idle off", 1'b0, act)
        `CHK("profile held", 1'b0, pst)
        en = 1;
        `WAITF(act)
        tick(2);
        `CHK("current", 16'h0123, cur)
        en = 0;
        tick(4);
        `CHK("abandon", 1'b0, act)
        `CHK("busy kept", 1'b1, busy)
        ans = 1;
        en = 1;
        `WAITF(!busy)
        tick(2);
        `CHK("encoder", 6'(MPI_SRC_ENC), src)
        `CHK("profile go", 1'b1, pst)
        en = 0;
        wr(MPI_IDX_OPTIONS, 16'h0004);
        wr(MPI_IDX_METHOD, MPI_SEL_ALGO);
        en = 1;
        `WAITF(act)
        tick(1);
        `CHK("offset", hofs, ang)
        `WAITF(!busy)
        en = 0;
        ans = 0;
        wr(MPI_IDX_OPTIONS, 16'h0001);
        wr(MPI_IDX_METHOD, MPI_SEL_ALGO);
        en = 1;
        `WAITF(!busy)
        tick(1);
        `CHK("zero", MPI_ANGLE_ZERO, ang)
        en = 0;
        ans = 2;
        wr(MPI_IDX_OPTIONS, 16'h0002);
        wr(MPI_IDX_METHOD, MPI_SEL_ALGO);
        en = 1;
        `WAITF(err)
        `CHK("no timeout", 1'b0, tmo)
        `CHK("fail busy", 1'b1, busy)
        `CHK("disable", 1'b1, dis)
        tick(1);
        `CHK("step", MPI_ANGLE_90, ang)
        en = 0;
        ans = 0;
        wr(MPI_IDX_DURATION, 16'h0000);
        wr(MPI_IDX_METHOD, MPI_SEL_HALL_ENC);
        `CHK("cleared", 1'b0, err)
        wr(MPI_IDX_METHOD, MPI_SEL_ALGO);
        en = 1;
        `WAITF(err)
        `CHK("timeout", 1'b1, tmo)
        `CHK("paced", 1'b1, (i >= MPI_TICK_CYC) && (i <= MPI_TICK_CYC + 8))
        conclude();
    end
endmodule
